// ==== spw_pkg.sv ====
// constants shared by the sixteen-bit pwm block
package spw_pkg;
   // ---------------------------------------------------------------
   // structure
   // ---------------------------------------------------------------
   localparam int          NUM_CH      = 2;        // pwm channels
   localparam int          CNT_W       = 16;       // counter resolution
   localparam int          ADDR_W      = 8;        // byte address width
   localparam logic [7:0]  CH_STRIDE   = 8'h20;    // bytes per channel
   // ---------------------------------------------------------------
   // register offsets inside a channel, and the shared register
   // ---------------------------------------------------------------
   localparam logic [4:0]  OFS_CTRL    = 5'h00;    // module_control_register
   localparam logic [4:0]  OFS_CLKSEL  = 5'h04;    // counter_clock_select_register
   localparam logic [4:0]  OFS_PERIOD  = 5'h08;    // period event count
   localparam logic [4:0]  OFS_DUTY    = 5'h0C;    // duty event count
   localparam logic [4:0]  OFS_COUNT   = 5'h10;    // running counter, read only
   localparam logic [7:0]  OFS_GLOBAL  = 8'h40;    // global_enable_register
   // ---------------------------------------------------------------
   // control register fields
   // ---------------------------------------------------------------
   localparam int          BIT_EN      = 0;        // module enable
   localparam int          BIT_INV     = 1;        // output_invert_bit
   localparam int          BIT_OUT     = 2;        // output state
   localparam int          BIT_SWMODE  = 3;        // software output mode
   // ---------------------------------------------------------------
   // counter clock sources
   // ---------------------------------------------------------------
   localparam logic [1:0]  SEL_SYS     = 2'h0;     // every system clock
   localparam logic [1:0]  SEL_INSTR   = 2'h1;     // instruction clock, clock/4
   localparam logic [1:0]  SEL_DIV16   = 2'h2;     // clock/16
   localparam logic [1:0]  SEL_EXT     = 2'h3;     // rising edge of external input
   localparam logic [3:0]  INSTR_LAST  = 4'h3;     // prescale value ending clock/4
   localparam logic [3:0]  DIV16_LAST  = 4'hF;     // prescale value ending clock/16
   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [15:0] RST_PERIOD  = 16'hFFFF;
   localparam logic [15:0] RST_DUTY    = 16'h0000;
   localparam logic [1:0]  RST_CLKSEL  = SEL_SYS;
endpackage : spw_pkg

// ==== spw_sync.sv ====
// two-stage resampler of a level onto the instruction clock tick
`timescale 1ns/100ps
`default_nettype none
module spw_sync (
   // clock and reset
   input  wire logic clock,
   input  wire logic rstn,
   // sample strobe and level
   input  wire logic tick,
   input  wire logic din,
   output logic      dout
);
   typedef struct packed {
      logic first;   // first stage, read only by second
      logic second;  // resynchronised level
   } spw_sync_s;

   spw_sync_s s, next_s;

   // -----------------------------------------------------------------
   // next state: both stages move only on the instruction tick
   // -----------------------------------------------------------------
   always_comb begin
      next_s = s;
      if (tick) begin
         next_s.first  = din;
         next_s.second = s.first;
      end
   end

   // register the state
   always_ff @(posedge clock) begin
      if (!rstn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign dout = s.second;
endmodule : spw_sync
`default_nettype wire

// ==== spw_chan.sv ====
// one pwm channel: its own counter, period and duty compare, polarity
`timescale 1ns/100ps
`default_nettype none
module spw_chan
   import spw_pkg::*;
(
   // clock and reset
   input  wire logic             clock,
   input  wire logic             rstn,
   // control
   input  wire logic             enable,
   input  wire logic             invert,
   input  wire logic             swMode,
   input  wire logic             swLevel,
   input  wire logic             tick,
   input  wire logic [CNT_W-1:0] period,
   input  wire logic [CNT_W-1:0] duty,
   // results
   output logic                  level,
   output logic      [CNT_W-1:0] count,
   output logic                  pwmOut
);
   typedef struct packed {
      logic [CNT_W-1:0] count;  // running counter
      logic             level;  // waveform before polarity
      logic             outp;   // pin level after polarity
   } spw_chan_s;

   spw_chan_s s, next_s;
   logic      lvl;              // level about to be registered

   // -----------------------------------------------------------------
   // counter and compare
   // -----------------------------------------------------------------
   always_comb begin
      next_s = s;
      lvl    = s.level;
      if (!enable) begin
         next_s.count = '0;
         lvl          = swMode ? swLevel : 1'b0;
      end else if (tick) begin
         if (s.count >= period) begin
            next_s.count = '0;
         end else begin
            next_s.count = s.count + 16'h0001;
         end
         // high from period start until the duty match
         lvl = swMode ? swLevel : (next_s.count < duty);
      end else if (swMode) begin
         lvl = swLevel;
      end
      next_s.level = lvl;
      next_s.outp  = lvl ^ invert;
   end

   // register the state
   always_ff @(posedge clock) begin
      if (!rstn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign level  = s.level;
   assign count  = s.count;
   assign pwmOut = s.outp;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   chk_period_wrap: assert property (
      @(posedge clock) disable iff (!rstn)
      (enable && tick && s.count >= period) |=> (s.count == '0))
      else $error("counter did not restart at period match");

   chk_disabled_hold: assert property (
      @(posedge clock) disable iff (!rstn)
      !enable |=> (s.count == '0))
      else $error("counter ran while disabled");

   chk_polarity: assert property (
      @(posedge clock) disable iff (!rstn)
      ##1 (s.outp == (s.level ^ $past(invert))))
      else $error("output polarity wrong");

   chk_duty_level: assert property (
      @(posedge clock) disable iff (!rstn)
      (enable && tick && !swMode) |=> (s.level == (s.count < $past(duty))))
      else $error("level disagrees with duty compare");

   chk_sw_drive: assert property (
      @(posedge clock) disable iff (!rstn)
      swMode |=> (s.level == $past(swLevel)))
      else $error("software level not driven");
endmodule : spw_chan
`default_nettype wire

// ==== spw_top.sv ====
// sixteen-bit pwm block with its avalon register slave
// ---------------------------------------------------------------------
// ---------------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
module spw_top
   import spw_pkg::*;
(
   // clock and reset
   input  wire logic                     clock,
   input  wire logic                     rstn,
   // avalon-mm slave
   input  wire logic [spw_pkg::ADDR_W-1:0] address,
   input  wire logic                     read,
   input  wire logic                     write,
   input  wire logic [31:0]              writedata,
   output logic      [31:0]              readdata,
   output logic                          waitrequest,
   // external counter clock source, synchronous input
   input  wire logic                     extClock,
   // modulated outputs toward the pin routing logic
   output logic      [spw_pkg::NUM_CH-1:0] pwmOut
);
   import spw_pkg::*;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic                          waitrequest;  // slave busy
      logic [31:0]                   readdata;     // read answer
      logic [NUM_CH-1:0]             enable;       // per channel enable
      logic [NUM_CH-1:0]             invert;       // polarity
      logic [NUM_CH-1:0]             swMode;       // software output mode
      logic [NUM_CH-1:0]             swLevel;      // software output level
      logic [NUM_CH-1:0][1:0]        clkSel;       // counter clock select
      logic [NUM_CH-1:0][CNT_W-1:0]  period;       // period event count
      logic [NUM_CH-1:0][CNT_W-1:0]  duty;         // duty event count
      logic [3:0]                    prescale;     // free running divider
      logic                          extPrev;      // last external level
   } spw_top_s;

   spw_top_s s, next_s;

   logic [NUM_CH-1:0]            chTick;       // counter clock per channel
   logic [NUM_CH-1:0]            chLevel;      // channel waveform
   logic [NUM_CH-1:0]            outState;     // level seen by software
   logic [NUM_CH-1:0][CNT_W-1:0] chCount;      // counters for readback
   logic                         instrTick;    // clock/4
   logic                         div16Tick;    // clock/16
   logic                         extTick;      // external rising edge
   logic                         accept;       // request taken this cycle
   logic                         hasCh;        // address lands in a channel
   logic                         chIdx;        // channel addressed
   logic [4:0]                   ofs;          // offset inside channel

   // ---------------------------------------------------------------
   // clock sources
   // ---------------------------------------------------------------
   assign instrTick = (s.prescale[1:0] == INSTR_LAST[1:0]);
   assign div16Tick = (s.prescale == DIV16_LAST);
   assign extTick   = extClock && !s.extPrev;

   // each channel picks its own counter clock
   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         case (s.clkSel[i])
            SEL_SYS:   chTick[i] = 1'b1;
            SEL_INSTR: chTick[i] = instrTick;
            SEL_DIV16: chTick[i] = div16Tick;
            SEL_EXT:   chTick[i] = extTick;
            default:   chTick[i] = 1'b1;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // channels and output state resampling
   // ---------------------------------------------------------------
   generate
      for (genvar g = 0; g < NUM_CH; g++) begin : gCh
         spw_chan uChan (
            .clock   (clock),
            .rstn    (rstn),
            .enable  (s.enable[g]),
            .invert  (s.invert[g]),
            .swMode  (s.swMode[g]),
            .swLevel (s.swLevel[g]),
            .tick    (chTick[g]),
            .period  (s.period[g]),
            .duty    (s.duty[g]),
            .level   (chLevel[g]),
            .count   (chCount[g]),
            .pwmOut  (pwmOut[g])
         );
         // state bit follows the instruction clock, not the counter
         spw_sync uSync (
            .clock (clock),
            .rstn  (rstn),
            .tick  (instrTick),
            .din   (chLevel[g]),
            .dout  (outState[g])
         );
      end
   endgenerate

   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   assign hasCh  = (address < (CH_STRIDE * 8'(NUM_CH)));
   assign chIdx  = address[5];
   assign ofs    = address[4:0];
   // a request completes on the edge where waitrequest is seen low
   assign accept = (read || write) && !s.waitrequest;

   // ---------------------------------------------------------------
   // next state: bus slave and register file
   // ---------------------------------------------------------------
   always_comb begin
      next_s          = s;
      next_s.prescale = s.prescale + 4'h1;
      next_s.extPrev  = extClock;
      // one-cycle low waitrequest per request, data with it
      if ((read || write) && s.waitrequest) begin
         next_s.waitrequest = 1'b0;
         next_s.readdata    = '0;
         if (read && hasCh) begin
            case (ofs)
               OFS_CTRL: begin
                  next_s.readdata[BIT_EN]     = s.enable[chIdx];
                  next_s.readdata[BIT_INV]    = s.invert[chIdx];
                  next_s.readdata[BIT_OUT]    = outState[chIdx];
                  next_s.readdata[BIT_SWMODE] = s.swMode[chIdx];
               end
               OFS_CLKSEL: next_s.readdata[1:0]       = s.clkSel[chIdx];
               OFS_PERIOD: next_s.readdata[CNT_W-1:0] = s.period[chIdx];
               OFS_DUTY:   next_s.readdata[CNT_W-1:0] = s.duty[chIdx];
               OFS_COUNT:  next_s.readdata[CNT_W-1:0] = chCount[chIdx];
               default:    next_s.readdata            = '0;
            endcase
         end else if (read && address == OFS_GLOBAL) begin
            next_s.readdata[NUM_CH-1:0] = s.enable;
         end
      end else begin
         next_s.waitrequest = 1'b1;
      end
      // writes take effect on the accepting edge
      if (accept && write) begin
         if (hasCh) begin
            case (ofs)
               OFS_CTRL: begin
                  next_s.enable[chIdx] = writedata[BIT_EN];
                  next_s.invert[chIdx] = writedata[BIT_INV];
                  next_s.swMode[chIdx] = writedata[BIT_SWMODE];
                  // output bit only writable in software mode
                  if (writedata[BIT_SWMODE]) begin
                     next_s.swLevel[chIdx] = writedata[BIT_OUT];
                  end
               end
               OFS_CLKSEL: next_s.clkSel[chIdx] = writedata[1:0];
               OFS_PERIOD: next_s.period[chIdx] = writedata[CNT_W-1:0];
               OFS_DUTY:   next_s.duty[chIdx]   = writedata[CNT_W-1:0];
               default:    next_s.period        = s.period;
            endcase
         end else if (address == OFS_GLOBAL) begin
            // one write enables every selected channel together
            next_s.enable = s.enable | writedata[NUM_CH-1:0];
         end
      end
   end

   // register the state
   always_ff @(posedge clock) begin
      if (!rstn) begin
         s             <= '0;
         s.waitrequest <= 1'b1;
         for (int i = 0; i < NUM_CH; i++) begin
            s.clkSel[i] <= RST_CLKSEL;
            s.period[i] <= RST_PERIOD;
            s.duty[i]   <= RST_DUTY;
         end
      end else begin
         s <= next_s;
      end
   end

   assign waitrequest = s.waitrequest;
   assign readdata    = s.readdata;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   chk_wait_pulse: assert property (
      @(posedge clock) disable iff (!rstn)
      !s.waitrequest |=> s.waitrequest)
      else $error("waitrequest low for more than one cycle");

   chk_global_enable: assert property (
      @(posedge clock) disable iff (!rstn)
      (accept && write && address == OFS_GLOBAL)
      |=> ((s.enable & $past(writedata[NUM_CH-1:0])) == $past(writedata[NUM_CH-1:0])))
      else $error("global enable did not set channel enables");

   chk_sync_delay: assert property (
      @(posedge clock) disable iff (!rstn)
      ##1 !$past(instrTick) |-> $stable(outState))
      else $error("output state changed between instruction ticks");

   chk_ctrl_enable: assert property (
      @(posedge clock) disable iff (!rstn)
      (accept && write && hasCh && ofs == OFS_CTRL && !chIdx)
      |=> (s.enable[0] == $past(writedata[BIT_EN])))
      else $error("channel enable write lost");

   // same for the second channel's enable bit
   chk_enable_second: assert property (
      @(posedge clock) disable iff (!rstn)
      (accept && write && hasCh && ofs == OFS_CTRL && chIdx)
      |=> (s.enable[1] == $past(writedata[BIT_EN])))
      else $error("second channel enable write lost");

   // an idle bus never sees waitrequest low
   chk_wait_idle: assert property (
      @(posedge clock) disable iff (!rstn)
      !(read || write) |=> s.waitrequest)
      else $error("waitrequest dropped with no request");

   // counts sit in the low half, the upper half reads zero
   chk_read_upper: assert property (
      @(posedge clock) disable iff (!rstn)
      !s.waitrequest |-> (s.readdata[31:CNT_W] == '0))
      else $error("upper read data not zero");

   // software reads the resynchronised level, not the raw one
   chk_read_state: assert property (
      @(posedge clock) disable iff (!rstn)
      (read && s.waitrequest && hasCh && ofs == OFS_CTRL)
      |=> (s.readdata[BIT_OUT] == $past(outState[chIdx])))
      else $error("control read lost the output state bit");

   // the instruction tick comes every fourth clock
   chk_instr_tick: assert property (
      @(posedge clock) disable iff (!rstn)
      instrTick |=> !instrTick ##1 !instrTick ##1 !instrTick ##1 instrTick)
      else $error("instruction tick spacing wrong");

   // outside software mode a control write keeps the software level
   chk_sw_lock: assert property (
      @(posedge clock) disable iff (!rstn)
      (accept && write && hasCh && ofs == OFS_CTRL && !writedata[BIT_SWMODE])
      |=> $stable(s.swLevel))
      else $error("software level written outside software mode");

   // the running counter place takes no write
   chk_count_ro: assert property (
      @(posedge clock) disable iff (!rstn)
      (accept && write && hasCh && ofs == OFS_COUNT)
      |=> ($stable(s.period) && $stable(s.duty)))
      else $error("write to counter place changed a register");

   // period count of channel zero lands as written
   chk_period_write: assert property (
      @(posedge clock) disable iff (!rstn)
      (accept && write && hasCh && ofs == OFS_PERIOD && !chIdx)
      |=> (s.period[0] == $past(writedata[CNT_W-1:0])))
      else $error("period write lost");

   // zeros in a global write leave running channels alone
   chk_global_keep: assert property (
      @(posedge clock) disable iff (!rstn)
      (accept && write && address == OFS_GLOBAL)
      |=> ((s.enable & $past(s.enable)) == $past(s.enable)))
      else $error("global write cleared an enable");

   // the shared register reads back every channel enable
   chk_global_read: assert property (
      @(posedge clock) disable iff (!rstn)
      (read && s.waitrequest && address == OFS_GLOBAL)
      |=> (s.readdata[NUM_CH-1:0] == $past(s.enable)))
      else $error("global read disagrees with enables");

   // reads outside the map answer zero
   chk_unmapped_zero: assert property (
      @(posedge clock) disable iff (!rstn)
      (read && s.waitrequest && !hasCh && address != OFS_GLOBAL)
      |=> (s.readdata == '0))
      else $error("unmapped read not zero");
endmodule : spw_top
`default_nettype wire

// ==== spw_pin_model.sv ====
// behavioural model of the port pin that the pwm output is routed to
`timescale 1ns/100ps
`default_nettype none
module spw_pin_model
   import spw_pkg::*;
(
   // pwm outputs of the block
   input  wire logic [spw_pkg::NUM_CH-1:0] pwmOut,
   // software pin setup
   input  wire logic                       routeSel,
   input  wire logic                       routeEn,
   input  wire logic                       pinDirOut,
   input  wire logic                       portLatch,
   // level seen on the pin
   output logic                            pinLevel
);
   // ---------------------------------------------------------------
   // pin mux
   // ---------------------------------------------------------------
   // an input pin is not driven by the pwm: show the opposite level
   // so a missing direction setup can never pass for a match
   always_comb begin
      if (pinDirOut && routeEn) begin
         pinLevel = pwmOut[routeSel];
      end else if (pinDirOut) begin
         pinLevel = portLatch;
      end else begin
         pinLevel = ~pwmOut[routeSel];
      end
   end
endmodule : spw_pin_model
`default_nettype wire

// ==== tb_sixteen_bit_pwm_output.sv ====
// self-checking testbench of the sixteen-bit pwm block
`timescale 1ns/100ps
`default_nettype none
module tb_sixteen_bit_pwm_output;
   import spw_pkg::*;
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   logic              clock;      // system clock
   logic              rstn;       // synchronous reset, active low
   logic [7:0]        address;    // bus address
   logic              read;       // bus read request
   logic              write;      // bus write request
   logic [31:0]       writedata;  // bus write data
   logic [31:0]       readdata;   // bus read data
   logic              waitrequest;// bus busy
   logic              extClock;   // external count source
   logic [NUM_CH-1:0] pwmOut;     // modulated outputs
   logic              routeSel;   // channel routed to the pin
   logic              routeEn;    // software route of the pwm to the pin
   logic              pinDirOut;  // pin direction set to output
   logic              pinLevel;   // pin level from the model
   int                failCount;  // mismatches
   int                cmpCount;   // comparisons
   logic [15:0]       dutyTab [4] = '{16'h0000, 16'h0001, 16'h0002, 16'h0004};
   int                hiTab   [4] = '{0, 10, 20, 40};
   // ---------------------------------------------------------------
   // design and pin model
   // ---------------------------------------------------------------
   spw_top dut (.clock(clock), .rstn(rstn), .address(address), .read(read),
      .write(write), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .extClock(extClock), .pwmOut(pwmOut));
   spw_pin_model pin (.pwmOut(pwmOut), .routeSel(routeSel), .routeEn(routeEn),
      .pinDirOut(pinDirOut), .portLatch(1'b0), .pinLevel(pinLevel));
   // ---------------------------------------------------------------
   // clock and watchdog
   // ---------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // cuts a hung run short
   initial begin
      repeat (20000) @(posedge clock);
      failCount++;
      closeOut();
   end
   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   // byte address of a channel register
   function automatic logic [7:0] ra(input int ch, input logic [4:0] ofs);
      return {2'h0, ch[0], ofs};
   endfunction : ra
   // one compare, reported at once on mismatch
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmpCount++;
      if (got !== exp) begin
         failCount++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   // avalon access: hold the request until waitrequest is seen low
   task automatic busAccess(input logic rd, input logic [7:0] a,
                            input logic [31:0] d, output logic [31:0] q);
      address   <= a;
      writedata <= d;
      read      <= rd;
      write     <= ~rd;
      do @(posedge clock); while (waitrequest !== 1'b0);
      q = readdata;
      read  <= 1'b0;
      write <= 1'b0;
      @(posedge clock);
   endtask : busAccess
   task automatic busWrite(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      busAccess(1'b0, a, d, q);
   endtask : busWrite
   task automatic readCheck(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      busAccess(1'b1, a, 32'h0000_0000, q);
      check(q, exp);
   endtask : readCheck
   // counts high cycles of the pin over a whole number of periods
   task automatic measure(input logic ch, input int cycles, input int exp);
      int hi;
      hi = 0;
      routeSel <= ch;
      repeat (40) @(posedge clock);
      repeat (cycles) begin
         @(posedge clock);
         if (pinLevel === 1'b1) hi++;
      end
      check(32'(hi), 32'(exp));
   endtask : measure
   // prints counts and verdict, ends the run
   task automatic closeOut();
      $display("comparisons %0d mismatches %0d", cmpCount, failCount);
      if (failCount == 0 && cmpCount > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : closeOut
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      failCount = 0;
      cmpCount  = 0;
      rstn = 1'b0; address = 8'h00; read = 1'b0; write = 1'b0;
      writedata = 32'h0000_0000; extClock = 1'b0; routeSel = 1'b0;
      routeEn = 1'b0;
      pinDirOut = 1'b0;
      repeat (12) @(posedge clock);
      rstn <= 1'b1;
      @(posedge clock);
      // route the pwm to the pin and make the pin an output
      routeEn   <= 1'b1;
      pinDirOut <= 1'b1;
      // reset values and an unmapped place
      readCheck(ra(0, OFS_PERIOD), 32'h0000_FFFF);
      readCheck(ra(0, OFS_DUTY), 32'h0000_0000);
      readCheck(ra(1, OFS_CLKSEL), 32'h0000_0000);
      readCheck(ra(0, OFS_CTRL), 32'h0000_0000);
      readCheck(8'h14, 32'h0000_0000);
      check(32'(pwmOut), 32'h0000_0000);
      // inversion while disabled, running counter is read only
      busWrite(ra(0, OFS_CTRL), 32'h0000_0002);
      repeat (4) @(posedge clock);
      check(32'(pwmOut), 32'h0000_0001);
      busWrite(ra(0, OFS_COUNT), 32'h0000_1234);
      readCheck(ra(0, OFS_COUNT), 32'h0000_0000);
      busWrite(ra(0, OFS_PERIOD), 32'h0001_2345);
      readCheck(ra(0, OFS_PERIOD), 32'h0000_2345);
      // duty table on channel 0, period 3 at full clock rate
      busWrite(ra(0, OFS_PERIOD), 32'h0000_0003);
      busWrite(ra(0, OFS_CTRL), 32'h0000_0001);
      for (int i = 0; i < 4; i++) begin
         busWrite(ra(0, OFS_DUTY), 32'(dutyTab[i]));
         measure(1'b0, 40, hiTab[i]);
      end
      busWrite(ra(0, OFS_DUTY), 32'h0000_0001);
      busWrite(ra(0, OFS_CTRL), 32'h0000_0003);
      measure(1'b0, 40, 30);
      // channel 1 through each internal clock source, channel 0 running
      busWrite(ra(1, OFS_PERIOD), 32'h0000_0001);
      busWrite(ra(1, OFS_DUTY), 32'h0000_0001);
      busWrite(ra(1, OFS_CTRL), 32'h0000_0001);
      for (int s = 0; s < 3; s++) begin
         busWrite(ra(1, OFS_CLKSEL), 32'(s));
         measure(1'b1, 20 << (2 * s), 10 << (2 * s));
      end
      // external source: five rising edges give five counts
      busWrite(ra(1, OFS_CTRL), 32'h0000_0000);
      busWrite(ra(1, OFS_PERIOD), 32'h0000_FFFF);
      busWrite(ra(1, OFS_CLKSEL), 32'(SEL_EXT));
      busWrite(ra(1, OFS_CTRL), 32'h0000_0001);
      repeat (5) begin
         extClock <= 1'b1;
         repeat (2) @(posedge clock);
         extClock <= 1'b0;
         repeat (2) @(posedge clock);
      end
      repeat (6) @(posedge clock);
      readCheck(ra(1, OFS_COUNT), 32'h0000_0005);
      // software output level, state bit lags on the instruction clock
      // stop channel 0 first: its waveform would alias the clock/4 sampling
      busWrite(ra(0, OFS_CTRL), 32'h0000_0000);
      repeat (12) @(posedge clock);
      busWrite(ra(0, OFS_CTRL), 32'h0000_000C);
      readCheck(ra(0, OFS_CTRL), 32'h0000_0008);
      check(32'(pwmOut[0]), 32'h0000_0001);
      repeat (12) @(posedge clock);
      readCheck(ra(0, OFS_CTRL), 32'h0000_000C);
      busWrite(ra(0, OFS_CTRL), 32'h0000_000E);
      repeat (2) @(posedge clock);
      check(32'(pwmOut[0]), 32'h0000_0000);
      busWrite(ra(0, OFS_CTRL), 32'h0000_0004);
      repeat (12) @(posedge clock);
      readCheck(ra(0, OFS_CTRL), 32'h0000_0000);
      // shared enable register starts both channels, zeros leave them alone
      busWrite(ra(1, OFS_CTRL), 32'h0000_0000);
      busWrite(OFS_GLOBAL, 32'h0000_0003);
      readCheck(OFS_GLOBAL, 32'h0000_0003);
      busWrite(OFS_GLOBAL, 32'h0000_0000);
      readCheck(OFS_GLOBAL, 32'h0000_0003);
      measure(1'b0, 40, 10);
      closeOut();
   end
endmodule : tb_sixteen_bit_pwm_output
`default_nettype wire
